// File: core/audio_level_defs.vh
`ifndef AUDIO_LEVEL_DEFS_VH
`define AUDIO_LEVEL_DEFS_VH
// ==========================================
// register offsets
`define A_STEP 12'h067
`define A_DIV 12'h068
`define A_Q0_LO 12'hB00
`define A_Q0_MID 12'hB01
`define A_Q0_DEP 12'hB02
`define A_Q0_HI 12'hB03
`define A_Q1_LO 12'hB04
`define A_Q1_MID 12'hB05
`define A_Q1_DEP 12'hB06
`define A_Q1_HI 12'hB07
`define A_Q2_LO 12'hB08
`define A_Q2_MID 12'hB09
`define A_Q2_DEP 12'hB0A
`define A_Q2_HI 12'hB0B
`define A_Q0_LOW_TH 12'hB0C
`define A_Q0_HIGH_TH 12'hB0D
`define A_Q1_HIGH_TH 12'hB0E
`define A_Q2_HIGH_TH 12'hB0F
`define A_QEN 12'hB10
`define A_QSTAT 12'hB13
`define A_LCTL 12'hB41
`define A_RCTL 12'hB42
`define A_MAXG 12'hB43
`define A_HIGH_T 12'hB44
`define A_LOW_T 12'hB46
`define A_NOISE 12'hB48
`define A_LDIG 12'hB4D
`define A_RDIG 12'hB4E
`define A_MODE 12'hB54
`define A_LPGA 12'hB5E
`define A_RPGA 12'hB5F
`define A_SPEED 12'hB60
`define A_LTGT 12'hB61
`define A_LCUR 12'hB62
`define A_MAN1 12'hB63
`define A_RTGT 12'hB65
`define A_RCUR 12'hB66
// ==========================================
// field positions
`define B_AUTO 7
`define B_ANALOG 0
`define B_MAN1 7
`define B_BOOST 6
`define B_REACHED 7
`define B_CLKEN 7
// ==========================================
// reset values
`define R_STEP 8'h00
`define R_DIV 8'h02
`define R_Q0_MID 8'h40
`define R_Q1_MID 8'h48
`define R_Q2_MID 8'h3C
`define R_Q_HI 8'h04
`define R_Q01_DEP 8'h7F
`define R_Q2_DEP 8'h3F
`define R_Q0_LOW_TH 8'h20
`define R_Q0_HIGH_TH 8'h60
`define R_Q12_HIGH_TH 8'h20
`define R_QEN 8'hF9
`define R_ZERO 8'h00
`endif

// File: core/level_channel.v
/*
  one audio channel of the level controller: pga gain (auto or ramp)
  and digital gain (auto or fixed coefficient).
  assumes level codes and targets share one half-db scale.
*/
`timescale 1ns/10ps
`default_nettype none
module level_channel (
  input wire clk,
  input wire rst,
  input wire auto_en,
  input wire analog_mode,
  input wire manual1,
  input wire [6:0] min_gain,
  input wire [6:0] max_gain,
  input wire [6:0] high_target,
  input wire [6:0] low_target,
  input wire [6:0] noise_level,
  input wire [6:0] ramp_target,
  input wire target_wr,
  input wire [7:0] speed,
  input wire [6:0] level,
  input wire level_valid,
  output reg [6:0] pga_gain,
  output reg [6:0] dig_gain,
  output reg reached
);
  // ==========================================
  // comparison on level plus applied gain
  wire [6:0] gain_used = analog_mode ? pga_gain : dig_gain;
  wire [7:0] measured = {1'b0, level} + {1'b0, gain_used};
  wire is_noise = measured < {1'b0, noise_level};
  wire too_loud = measured > {1'b0, high_target};
  wire too_quiet = measured < {1'b0, low_target};
  reg [6:0] next_auto;
  always @* begin
    next_auto = gain_used;
    if (!is_noise) begin
      if (too_loud && gain_used > min_gain)
        next_auto = gain_used - 7'h01;
      else if (too_quiet && gain_used < max_gain)
        next_auto = gain_used + 7'h01;
    end
    // clamp into the window even if limits were moved
    if (next_auto < min_gain)
      next_auto = min_gain;
    if (next_auto > max_gain)
      next_auto = max_gain;
  end
  // ==========================================
  // ramp pacing
  reg [7:0] tick_cnt;
  wire ramp_mode = !analog_mode && !manual1;
  wire tick = tick_cnt >= speed;
  wire arrive = ramp_mode && pga_gain == ramp_target;
  always @(posedge clk) begin
    if (rst) begin
      tick_cnt <= 8'h00;
      pga_gain <= 7'h00;
      dig_gain <= 7'h00;
      reached <= 1'b0;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
      if (analog_mode && auto_en && level_valid)
        pga_gain <= next_auto;
      else if (ramp_mode && tick && pga_gain != ramp_target)
        pga_gain <= pga_gain < ramp_target ? pga_gain + 7'h01 : pga_gain - 7'h01;
      if (!analog_mode && auto_en) begin
        if (level_valid)
          dig_gain <= next_auto;
      end else if (!analog_mode)
        dig_gain <= {1'b0, min_gain[5:0]};
      // new target voids the old arrival; equality persists, so it sets next cycle
      if (target_wr)
        reached <= 1'b0;
      else if (arrive)
        reached <= 1'b1;
    end
  end
endmodule // level_channel
`default_nettype wire

// File: core/audio_level_control.v
/*
  audio level controller with serial audio clock divider and dma audio
  queue configuration/threshold flags. registers on a plain byte port.
  assumes fill counts, level codes and 48 mhz tick synchronous to clk.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "audio_level_defs.vh"
module audio_level_control (
  input wire clk,
  input wire rst,
  input wire [11:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire [6:0] level_left,
  input wire [6:0] level_right,
  input wire level_valid,
  input wire tick_48m,
  input wire [11:0] queue0_fill,
  input wire [11:0] queue1_fill,
  input wire [11:0] queue2_fill,
  output wire [6:0] pga_gain_left,
  output wire [6:0] pga_gain_right,
  output reg pga_direct,
  output reg pga_boost,
  output reg [5:0] pga_post_code,
  output wire [6:0] dig_gain_left,
  output wire [6:0] dig_gain_right,
  output reg serial_clk,
  output reg [18:0] queue0_base,
  output reg [18:0] queue1_base,
  output reg [18:0] queue2_base,
  output reg [9:0] queue0_words,
  output reg [9:0] queue1_words,
  output reg [9:0] queue2_words,
  output reg [2:0] queue_in_en,
  output reg queue_irq
);
  // ==========================================
  // configuration registers
  reg [7:0] step, divisor;
  reg [7:0] q0_lo, q0_mid, q0_dep, q0_hi;
  reg [7:0] q1_lo, q1_mid, q1_dep, q1_hi;
  reg [7:0] q2_lo, q2_mid, q2_dep, q2_hi;
  reg [7:0] q0_low_th, q0_high_th, q1_high_th, q2_high_th, qen;
  reg [7:0] lctl, rctl, maxg, high_t, low_t, noise_t, mode, speed, man1;
  reg [6:0] ltgt, rtgt;
  reg [3:0] sticky;
  wire l_reached, r_reached;
  wire analog_mode = mode[`B_ANALOG];
  wire manual1 = man1[`B_MAN1];
  wire wr_ltgt = wr && addr == `A_LTGT;
  wire wr_rtgt = wr && addr == `A_RTGT;
  always @(posedge clk) begin
    if (rst) begin
      step <= `R_STEP;
      divisor <= `R_DIV;
      q0_lo <= `R_ZERO;
      q0_mid <= `R_Q0_MID;
      q0_dep <= `R_Q01_DEP;
      q0_hi <= `R_Q_HI;
      q1_lo <= `R_ZERO;
      q1_mid <= `R_Q1_MID;
      q1_dep <= `R_Q01_DEP;
      q1_hi <= `R_Q_HI;
      q2_lo <= `R_ZERO;
      q2_mid <= `R_Q2_MID;
      q2_dep <= `R_Q2_DEP;
      q2_hi <= `R_Q_HI;
      q0_low_th <= `R_Q0_LOW_TH;
      q0_high_th <= `R_Q0_HIGH_TH;
      q1_high_th <= `R_Q12_HIGH_TH;
      q2_high_th <= `R_Q12_HIGH_TH;
      qen <= `R_QEN;
      lctl <= `R_ZERO;
      rctl <= `R_ZERO;
      maxg <= `R_ZERO;
      high_t <= `R_ZERO;
      low_t <= `R_ZERO;
      noise_t <= `R_ZERO;
      mode <= `R_ZERO;
      speed <= `R_ZERO;
      man1 <= `R_ZERO;
      ltgt <= 7'h00;
      rtgt <= 7'h00;
    end else if (wr) begin
      case (addr)
        `A_STEP: step <= wdata;
        `A_DIV: divisor <= wdata;
        `A_Q0_LO: q0_lo <= wdata;
        `A_Q0_MID: q0_mid <= wdata;
        `A_Q0_DEP: q0_dep <= wdata;
        `A_Q0_HI: q0_hi <= wdata;
        `A_Q1_LO: q1_lo <= wdata;
        `A_Q1_MID: q1_mid <= wdata;
        `A_Q1_DEP: q1_dep <= wdata;
        `A_Q1_HI: q1_hi <= wdata;
        `A_Q2_LO: q2_lo <= wdata;
        `A_Q2_MID: q2_mid <= wdata;
        `A_Q2_DEP: q2_dep <= wdata;
        `A_Q2_HI: q2_hi <= wdata;
        `A_Q0_LOW_TH: q0_low_th <= wdata;
        `A_Q0_HIGH_TH: q0_high_th <= wdata;
        `A_Q1_HIGH_TH: q1_high_th <= wdata;
        `A_Q2_HIGH_TH: q2_high_th <= wdata;
        `A_QEN: qen <= wdata;
        `A_LCTL: lctl <= wdata;
        `A_RCTL: rctl <= wdata;
        `A_MAXG: maxg <= wdata;
        `A_HIGH_T: high_t <= wdata;
        `A_LOW_T: low_t <= wdata;
        `A_NOISE: noise_t <= wdata;
        `A_MODE: mode <= wdata;
        `A_SPEED: speed <= wdata;
        `A_MAN1: man1 <= wdata;
        `A_LTGT: ltgt <= wdata[6:0];
        `A_RTGT: rtgt <= wdata[6:0];
        default: ;
      endcase
    end
  end
  // ==========================================
  // regulators, one per channel
  // targets hold integer db in 6:1 and a half db in bit 0, so the
  // whole 6:0 field reads as a half-db count
  level_channel left_ch (
    .clk(clk),
    .rst(rst),
    .auto_en(lctl[`B_AUTO]),
    .analog_mode(analog_mode),
    .manual1(manual1),
    .min_gain(lctl[6:0]),
    .max_gain(maxg[6:0]),
    .high_target(high_t[6:0]),
    .low_target(low_t[6:0]),
    .noise_level(noise_t[6:0]),
    .ramp_target(ltgt),
    .target_wr(wr_ltgt),
    .speed(speed),
    .level(level_left),
    .level_valid(level_valid),
    .pga_gain(pga_gain_left),
    .dig_gain(dig_gain_left),
    .reached(l_reached)
  );
  level_channel right_ch (
    .clk(clk),
    .rst(rst),
    .auto_en(rctl[`B_AUTO]),
    .analog_mode(analog_mode),
    .manual1(manual1),
    .min_gain(rctl[6:0]),
    .max_gain(maxg[6:0]),
    .high_target(high_t[6:0]),
    .low_target(low_t[6:0]),
    .noise_level(noise_t[6:0]),
    .ramp_target(rtgt),
    .target_wr(wr_rtgt),
    .speed(speed),
    .level(level_right),
    .level_valid(level_valid),
    .pga_gain(pga_gain_right),
    .dig_gain(dig_gain_right),
    .reached(r_reached)
  );
  // ==========================================
  // direct two-stage pga setting
  // post code above 0x30 is out of range; clamped at 14 db
  always @(posedge clk) begin
    if (rst) begin
      pga_direct <= 1'b0;
      pga_boost <= 1'b0;
      pga_post_code <= 6'h00;
    end else begin
      pga_direct <= manual1;
      pga_boost <= man1[`B_BOOST];
      pga_post_code <= man1[5:0] > 6'h30 ? 6'h30 : man1[5:0];
    end
  end
  // ==========================================
  // serial audio clock
  // phase accumulator adds twice the step per 48 mhz tick, so output
  // toggles average 48m*2*step/divisor; needs divisor >= 2*step
  reg [8:0] phase;
  wire [8:0] next_phase = phase + {step[6:0], 1'b0};
  always @(posedge clk) begin
    if (rst) begin
      phase <= 9'h000;
      serial_clk <= 1'b0;
    end else if (!step[`B_CLKEN]) begin
      phase <= 9'h000;
      serial_clk <= 1'b0;
    end else if (tick_48m) begin
      if (next_phase >= {1'b0, divisor}) begin
        phase <= next_phase - {1'b0, divisor};
        serial_clk <= ~serial_clk;
      end else
        phase <= next_phase;
    end
  end
  // ==========================================
  // queue configuration outputs
  always @(posedge clk) begin
    if (rst) begin
      queue0_base <= 19'h00000;
      queue1_base <= 19'h00000;
      queue2_base <= 19'h00000;
      queue0_words <= 10'h000;
      queue1_words <= 10'h000;
      queue2_words <= 10'h000;
      queue_in_en <= 3'h0;
    end else begin
      queue0_base <= {q0_hi[2:0], q0_mid, q0_lo};
      queue1_base <= {q1_hi[2:0], q1_mid, q1_lo};
      queue2_base <= {q2_hi[2:0], q2_mid, q2_lo};
      queue0_words <= {q0_dep, 2'b00};
      queue1_words <= {q1_dep, 2'b00};
      queue2_words <= {q2_dep, 2'b00};
      queue_in_en <= qen[2:0];
    end
  end
  // ==========================================
  // queue threshold flags
  wire [3:0] live;
  assign live[0] = queue0_fill < {4'h0, q0_low_th};
  assign live[1] = queue0_fill > {4'h0, q0_high_th};
  assign live[2] = queue1_fill > {4'h0, q1_high_th};
  assign live[3] = queue2_fill > {4'h0, q2_high_th};
  wire [3:0] w1c = (wr && addr == `A_QSTAT) ? wdata[3:0] : 4'h0;
  always @(posedge clk) begin
    if (rst) begin
      sticky <= 4'h0;
      queue_irq <= 1'b0;
    end else begin
      // a crossing in the clearing cycle is kept
      sticky <= (sticky & ~w1c) | live;
      queue_irq <= |(((sticky & ~w1c) | live) & qen[7:4]);
    end
  end
  // ==========================================
  // read port
  wire l_auto_dig = !analog_mode && lctl[`B_AUTO];
  wire r_auto_dig = !analog_mode && rctl[`B_AUTO];
  always @(posedge clk) begin
    if (rst)
      rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        `A_STEP: rdata <= step;
        `A_DIV: rdata <= divisor;
        `A_Q0_LO: rdata <= q0_lo;
        `A_Q0_MID: rdata <= q0_mid;
        `A_Q0_DEP: rdata <= q0_dep;
        `A_Q0_HI: rdata <= q0_hi;
        `A_Q1_LO: rdata <= q1_lo;
        `A_Q1_MID: rdata <= q1_mid;
        `A_Q1_DEP: rdata <= q1_dep;
        `A_Q1_HI: rdata <= q1_hi;
        `A_Q2_LO: rdata <= q2_lo;
        `A_Q2_MID: rdata <= q2_mid;
        `A_Q2_DEP: rdata <= q2_dep;
        `A_Q2_HI: rdata <= q2_hi;
        `A_Q0_LOW_TH: rdata <= q0_low_th;
        `A_Q0_HIGH_TH: rdata <= q0_high_th;
        `A_Q1_HIGH_TH: rdata <= q1_high_th;
        `A_Q2_HIGH_TH: rdata <= q2_high_th;
        `A_QEN: rdata <= qen;
        `A_QSTAT: rdata <= {live, sticky};
        `A_LCTL: rdata <= lctl;
        `A_RCTL: rdata <= rctl;
        `A_MAXG: rdata <= maxg;
        `A_HIGH_T: rdata <= high_t;
        `A_LOW_T: rdata <= low_t;
        `A_NOISE: rdata <= noise_t;
        `A_LDIG: rdata <= {1'b0, l_auto_dig ? dig_gain_left : level_left};
        `A_RDIG: rdata <= {1'b0, r_auto_dig ? dig_gain_right : level_right};
        `A_MODE: rdata <= mode;
        `A_LPGA: rdata <= {1'b0, pga_gain_left};
        `A_RPGA: rdata <= {1'b0, pga_gain_right};
        `A_SPEED: rdata <= speed;
        `A_LTGT: rdata <= {l_reached, ltgt};
        `A_LCUR: rdata <= {1'b0, pga_gain_left};
        `A_MAN1: rdata <= man1;
        `A_RTGT: rdata <= {r_reached, rtgt};
        `A_RCUR: rdata <= {1'b0, pga_gain_right};
        default: rdata <= 8'h00;
      endcase
    end else
      rdata <= 8'h00;
  end
endmodule // audio_level_control
`default_nettype wire

// File: tb/audio_source_model.sv
/* far-side model: level sample path only, no gain stage; levels follow the
   bench request, strobes run free. assumes one 100 mhz clock. */
`timescale 1ns/10ps
`default_nettype none
module audio_source_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [6:0] want_left,
  input wire logic [6:0] want_right,
  output logic [6:0] level_left,
  output logic [6:0] level_right,
  output logic level_valid,
  output logic tick_48m
);
  // ========
  // strobes
  logic [1:0] div;
  logic [7:0] acc;
  // one sample in four cycles keeps regulation slow enough to watch
  always @(posedge clk) begin
    level_left <= want_left;
    level_right <= want_right;
    if (rst) begin
      div <= 2'h0;
      acc <= 8'h00;
      level_valid <= 1'b0;
      tick_48m <= 1'b0;
    end else begin
      div <= div + 2'h1;
      level_valid <= div == 2'h3;
      // 48 ticks per 100 cycles
      acc <= (acc >= 8'h34) ? acc - 8'h34 : acc + 8'h30;
      tick_48m <= acc >= 8'h34;
    end
  end
endmodule // audio_source_model
`default_nettype wire

// File: tb/audio_level_control_chk.sv
/* port checker for audio_level_control: bus, queue setup, manual gain,
   serial clock. bound from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
`include "audio_level_defs.vh"
module audio_level_control_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tick_48m,
  input wire logic [6:0] pga_gain_left,
  input wire logic pga_direct,
  input wire logic pga_boost,
  input wire logic [5:0] pga_post_code,
  input wire logic serial_clk,
  input wire logic [18:0] queue0_base,
  input wire logic [9:0] queue0_words,
  input wire logic [2:0] queue_in_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ========
  // assertions
  // write then a quiet cycle; outputs may lag the register a stage
  sequence s_wr(a);
    wr && addr == a ##1 !wr;
  endsequence
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_gain_read: assert property (rd && addr == `A_LPGA |=>
    rdata == {1'b0, $past(pga_gain_left)})
    else $error("pga gain readback wrong");
  a_target_back: assert property (wr && addr == `A_HIGH_T ##2
    rd && addr == `A_HIGH_T |=> rdata[6:0] == $past(wdata[6:0], 3))
    else $error("high target readback wrong");
  a_base_low: assert property (s_wr(`A_Q0_LO) |-> ##1
    queue0_base[7:0] == $past(wdata, 2))
    else $error("base low byte not applied");
  a_base_high: assert property (s_wr(`A_Q0_HI) |-> ##1
    queue0_base[18:16] == $past(wdata[2:0], 2))
    else $error("base high field not applied");
  a_depth_words: assert property (s_wr(`A_Q0_DEP) |-> ##1
    queue0_words == {$past(wdata, 2), 2'b00})
    else $error("capacity not depth times four");
  a_in_enable: assert property (s_wr(`A_QEN) |-> ##1
    queue_in_en == $past(wdata[2:0], 2))
    else $error("queue input enables not applied");
  a_direct_boost: assert property (s_wr(`A_MAN1) |-> ##1
    {pga_direct, pga_boost} == $past(wdata[7:6], 2))
    else $error("direct or boost not applied");
  a_post_clamp: assert property (s_wr(`A_MAN1) |-> ##1 pga_post_code ==
    ($past(wdata[5:0], 2) > 6'h30 ? 6'h30 : $past(wdata[5:0], 2)))
    else $error("post code wrong");
  // a forced low on disable may come without a tick, so rises only
  a_sclk_tick: assert property ($rose(serial_clk) |-> $past(tick_48m))
    else $error("serial clock rose without tick");
  a_pga_step: assert property ($changed(pga_gain_left) && !pga_direct &&
    !$past(wr) && !$past(wr, 2) |->
    7'(pga_gain_left - $past(pga_gain_left)) inside {7'h01, 7'h7F})
    else $error("pga gain moved more than one code");
  c_manual: cover property (s_wr(`A_MAN1));
  c_sclk: cover property ($rose(serial_clk));
  c_gain_read: cover property (rd && addr == `A_LPGA);
endmodule // audio_level_control_chk
`default_nettype wire

// File: tb/audio_level_control_bench.sv
/* bench for audio_level_control: register tasks, mode, queue flag and
   serial clock scenarios. assumes the source model and the checker. */
`timescale 1ns/10ps
`default_nettype none
`include "audio_level_defs.vh"
module audio_level_control_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] want_left = 7'h00;
  logic [6:0] want_right = 7'h00;
  logic [11:0] fill0 = 12'h030;
  logic [11:0] fill1 = 12'h000;
  logic [11:0] fill2 = 12'h000;
  logic [7:0] rdata;
  logic [6:0] level_left, level_right, pga_gain_left, pga_gain_right, dig_gain_left;
  logic level_valid, tick_48m, pga_direct, pga_boost, serial_clk, queue_irq;
  logic [5:0] pga_post_code;
  logic [6:0] dig_gain_right;
  logic [18:0] queue0_base, queue1_base, queue2_base;
  logic [9:0] queue0_words, queue1_words, queue2_words;
  logic [2:0] queue_in_en;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [11:0] ra [19] = '{12'h067, 12'h068, 12'hB00, 12'hB01, 12'hB02, 12'hB03, 12'hB04,
    12'hB05, 12'hB06, 12'hB07, 12'hB08, 12'hB09, 12'hB0A, 12'hB0B, 12'hB0C, 12'hB0D,
    12'hB0E, 12'hB0F, 12'hB10};
  logic [7:0] rv [19] = '{8'h00, 8'h02, 8'h00, 8'h40, 8'h7F, 8'h04, 8'h00, 8'h48, 8'h7F,
    8'h04, 8'h00, 8'h3C, 8'h3F, 8'h04, 8'h20, 8'h60, 8'h20, 8'h20, 8'hF9};
  logic [11:0] ta [4] = '{`A_HIGH_T, `A_LOW_T, `A_NOISE, `A_MAXG};
  logic [7:0] tv [4] = '{8'h40, 8'h30, 8'h10, 8'h20};
  logic [7:0] mv [3] = '{8'hF0, 8'hBF, 8'h85};
  always #5 clk = ~clk;
  audio_source_model i_audio_source_model (.clk, .rst, .want_left, .want_right,
    .level_left, .level_right, .level_valid, .tick_48m);
  audio_level_control i_audio_level_control (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .level_left, .level_right, .level_valid, .tick_48m, .queue0_fill(fill0),
    .queue1_fill(fill1), .queue2_fill(fill2), .pga_gain_left, .pga_gain_right, .pga_direct,
    .pga_boost, .pga_post_code, .dig_gain_left, .dig_gain_right, .serial_clk,
    .queue0_base, .queue1_base, .queue2_base, .queue0_words, .queue1_words,
    .queue2_words, .queue_in_en, .queue_irq);
  // ========
  // tasks
  task automatic complete_run;
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [18:0] seen, input logic [18:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), rdata, exp);
  endtask
  // bounded wait: regulation and ramps take a data-dependent time
  task automatic wait_val(input string name, input int sel, input logic [6:0] exp);
    logic [6:0] v;
    for (int n = 0; n < 600; n++) begin
      @(posedge clk);
      #1;
      v = sel == 0 ? dig_gain_left : sel == 1 ? pga_gain_left : pga_gain_right;
      if (v === exp)
        break;
    end
    chk(name, v, exp);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // ========
  // scenarios
  initial begin
    int nt;
    int ns;
    int t0;
    logic last;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 19; i++)
      rd_chk(ra[i], rv[i]);
    chk("q0_base", queue0_base, 19'h44000);
    chk("q0_words", queue0_words, 19'h001FC);
    chk("q1_base", queue1_base, 19'h44800);
    chk("q2_base", queue2_base, 19'h43C00);
    chk("q1_words", queue1_words, 19'h001FC);
    chk("q2_words", queue2_words, 19'h000FC);
    wr_reg(12'hB30, 8'h5A);
    rd_chk(12'hB30, 8'h00);
    wr_reg(`A_LPGA, 8'h55);
    rd_chk(`A_LPGA, 8'h00);
    wr_reg(`A_Q0_LO, 8'hAB);
    wr_reg(`A_Q0_MID, 8'hCD);
    wr_reg(`A_Q0_HI, 8'hFF);
    wr_reg(`A_Q0_DEP, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("q0_base", queue0_base, 19'h7CDAB);
    chk("q0_words", queue0_words, 19'h00004);
    wr_reg(`A_Q0_DEP, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      wr_reg(ta[i], tv[i]);
      rd_chk(ta[i], tv[i]);
    end
    chk("q0_words", queue0_words, 19'h003FC);
    @(posedge clk) want_left <= 7'h11;
    wr_reg(`A_LCTL, 8'h2A);
    wait_val("dig_l", 0, 7'h2A);
    rd_chk(`A_LDIG, 8'h11);
    @(posedge clk) want_left <= 7'h50;
    wr_reg(`A_LCTL, 8'h85);
    wait_val("dig_l", 0, 7'h05);
    @(posedge clk) want_left <= 7'h02;
    repeat (40) @(posedge clk);
    #1;
    chk("dig_l_hold", dig_gain_left, 7'h05);
    @(posedge clk) want_left <= 7'h20;
    wait_val("dig_l", 0, 7'h10);
    rd_chk(`A_LDIG, 8'h10);
    @(posedge clk) want_left <= 7'h08;
    wait_val("dig_l", 0, 7'h20);
    wr_reg(`A_LCTL, 8'h05);
    @(posedge clk) want_right <= 7'h50;
    wr_reg(`A_MODE, 8'h01);
    wr_reg(`A_RCTL, 8'h83);
    wait_val("pga_r", 2, 7'h03);
    @(posedge clk) want_right <= 7'h20;
    wait_val("pga_r", 2, 7'h10);
    rd_chk(`A_RPGA, 8'h10);
    wr_reg(`A_SPEED, 8'h03);
    wr_reg(`A_MODE, 8'h00);
    wr_reg(`A_LTGT, 8'h15);
    t0 = cycles;
    rd_chk(`A_LTGT, 8'h15);
    wait_val("pga_l", 1, 7'h15);
    chk("ramp_time", (cycles - t0) inside {[78:92]}, 1'b1);
    rd_chk(`A_LTGT, 8'h95);
    rd_chk(`A_LCUR, 8'h15);
    rd_chk(`A_RTGT, 8'h80);
    for (int i = 0; i < 3; i++) begin
      wr_reg(`A_MAN1, mv[i]);
      repeat (2) @(posedge clk);
      #1;
      chk("manual1", {pga_direct, pga_boost, pga_post_code}, {mv[i][7:6],
        mv[i][5:0] > 6'h30 ? 6'h30 : mv[i][5:0]});
    end
    wr_reg(`A_DIV, 8'h04);
    for (int s = 1; s < 3; s++) begin
      nt = 0;
      ns = 0;
      last = serial_clk;
      wr_reg(`A_STEP, 8'h80 | 8'(s));
      repeat (1000) begin
        @(posedge clk);
        #1;
        nt += tick_48m;
        ns += serial_clk !== last;
        last = serial_clk;
      end
      // toggles times divisor against ticks times twice the step
      chk("sclk_rate", (ns * 4 - nt * 2 * s) inside {[-8:8]}, 1'b1);
    end
    wr_reg(`A_STEP, 8'h02);
    repeat (3) @(posedge clk);
    #1;
    chk("sclk_off", serial_clk, 1'b0);
    @(posedge clk) fill0 <= 12'h010;
    rd_chk(`A_QSTAT, 8'h11);
    chk("irq", queue_irq, 1'b1);
    @(posedge clk) fill0 <= 12'h030;
    rd_chk(`A_QSTAT, 8'h01);
    wr_reg(`A_QSTAT, 8'h01);
    rd_chk(`A_QSTAT, 8'h00);
    chk("irq", queue_irq, 1'b0);
    @(posedge clk) fill2 <= 12'h021;
    rd_chk(`A_QSTAT, 8'h88);
    wr_reg(`A_QEN, 8'h07);
    @(posedge clk);
    fill0 <= 12'h061;
    fill1 <= 12'h021;
    rd_chk(`A_QSTAT, 8'hEE);
    chk("irq_masked", {queue_irq, queue_in_en}, 4'h7);
    chk("dig_l_man", dig_gain_left, 7'h05);
    chk("dig_r", dig_gain_right, 7'h10);
    rd_chk(`A_RDIG, 8'h10);
    complete_run();
  end
endmodule // audio_level_control_bench
bind audio_level_control audio_level_control_chk i_audio_level_control_chk (.clk(clk),
  .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .tick_48m(tick_48m), .pga_gain_left(pga_gain_left), .pga_direct(pga_direct),
  .pga_boost(pga_boost), .pga_post_code(pga_post_code), .serial_clk(serial_clk),
  .queue0_base(queue0_base), .queue0_words(queue0_words), .queue_in_en(queue_in_en));
`default_nettype wire
